// ==== hdl/disc_ctl.sv ====
`timescale 1ns/1ps
// ----------------------------------------
// Word FIFO in the data channel path
// ----------------------------------------
module word_fifo #(
    parameter int WIDTH = 16,
    parameter int DEPTH = 4
) (
    input  wire logic             clk,
    input  wire logic             rst_n,
    input  wire logic             flush,
    input  wire logic             in_valid,
    output logic                  in_ready,
    input  wire logic [WIDTH-1:0] in_data,
    output logic                  out_valid,
    input  wire logic             out_ready,
    output logic [WIDTH-1:0]      out_data
);
    localparam int AW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0]    wr_reg;
    logic [AW-1:0]    rd_reg;
    logic [AW:0]      cnt_reg;
    wire push = in_valid && in_ready;
    wire pop  = out_valid && out_ready;
    assign in_ready  = (cnt_reg != (AW+1)'(DEPTH)) && !flush;
    assign out_valid = (cnt_reg != '0);
    assign out_data  = mem[rd_reg];
    // Storage has no reset: only pointers matter
    always_ff @(posedge clk) begin
        if (push) begin
            mem[wr_reg] <= in_data;
        end
    end
    // Pointers; flush empties in one cycle
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            wr_reg  <= '0;
            rd_reg  <= '0;
            cnt_reg <= '0;
        end else if (flush) begin
            wr_reg  <= '0;
            rd_reg  <= '0;
            cnt_reg <= '0;
        end else begin
            wr_reg  <= push ? AW'(wr_reg + 1'b1) : wr_reg;
            rd_reg  <= pop ? AW'(rd_reg + 1'b1) : rd_reg;
            cnt_reg <= (AW+1)'(cnt_reg + push - pop);
        end
    end
endmodule

// ----------------------------------------
// Disc pack controller core
// ----------------------------------------
module disc_ctl
    import disc_ctl_pkg::*;
(
    input  wire logic        clk,
    input  wire logic        rst_n,
    input  wire logic        start_fn,
    input  wire logic        clear_fn,
    input  wire logic        pulse_fn,
    input  wire logic        load_disc_address_instr,
    input  wire logic        load_cmd_instr,
    input  wire logic        load_ptr_instr,
    input  wire logic [15:0] accumulator,
    output logic [15:0]      controller_flags,
    output logic [15:0]      disc_position_and_count,
    output logic [14:0]      word_ptr,
    output logic             busy,
    output logic             intr_req,
    output logic [3:0]       format_mode,
    output logic [3:0]       seek_strobe,
    output logic [1:0]       seek_kind,
    output logic [7:0]       seek_cyl,
    input  wire logic [3:0]  drive_seek_done,
    input  wire logic [3:0]  drive_seek_fail,
    input  wire logic [3:0]  drive_ready,
    input  wire logic [3:0]  drive_unsafe,
    input  wire logic        disc_word_valid,
    output logic             disc_word_ready,
    input  wire logic [15:0] disc_word,
    input  wire logic        sector_end,
    input  wire logic        check_mismatch,
    input  wire logic        addr_mismatch,
    output logic             chan_req,
    output logic [15:0]      chan_data,
    output logic [14:0]      chan_addr,
    input  wire logic        chan_ack
);
    import disc_ctl_pkg::*;
    // ----------------------------------------
    // Reset release
    // ----------------------------------------
    logic rs1_reg;
    logic rst_sync_n;
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            rs1_reg    <= 1'b0;
            rst_sync_n <= 1'b0;
        end else begin
            rs1_reg    <= 1'b1;
            rst_sync_n <= rs1_reg;
        end
    end

    // ----------------------------------------
    // State
    // ----------------------------------------
    logic [15:0]  da_reg;
    logic [15:0]  cmdcyl_reg;
    logic [14:0]  ptr_reg;
    logic         busy_reg;
    logic         done_reg;
    logic [3:0]   sdone_reg;
    logic [3:0]   seeking_reg;
    logic         seek_err_reg, end_err_reg, addr_err_reg, chk_err_reg, late_reg;
    logic [3:0]   fmt_reg;
    xfer_state_t  xs_reg;
    logic [15:0]  late_cnt_reg;
    logic         stop_reg;

    // Decoded fields and events
    wire [1:0] sel     = da_reg[DA_DRIVE_HI -: 2];
    wire [1:0] cmd     = cmdcyl_reg[9:8];
    wire       cmd_rw  = !cmd[1];
    wire       launch_rw   = start_fn && cmd_rw && !busy_reg && !clear_fn;
    wire       launch_seek = (pulse_fn || start_fn) && !cmd_rw && !clear_fn;
    wire [3:0] sel_hot = 4'b0001 << sel;
    wire       f_valid, f_ready;
    wire [15:0] f_data;
    wire       word_moved  = chan_req && chan_ack;
    wire [14:0] ptr_next   = load_ptr_instr ? accumulator[14:0]
                             : word_moved ? 15'(ptr_reg + 15'h1) : ptr_reg;
    // Ready is registered, so it rests a cycle after each word taken
    wire       took_word   = disc_word_valid && disc_word_ready;
    wire       late_hit    = (xs_reg != XS_IDLE) && chan_req
                             && (late_cnt_reg == 16'(LATE_CYCLES));
    wire [3:0] cnt_next    = da_reg[DA_CNT_HI:0] + 4'h1;
    wire       cnt_ovf     = (da_reg[DA_CNT_HI:0] == 4'hf);
    wire       last_sect   = (da_reg[DA_SECT_HI:DA_SECT_LO] == LAST_SECTOR);
    wire       last_surf   = (da_reg[DA_SURF_HI:DA_SURF_LO] == LAST_SURFACE);
    wire       sector_done = (xs_reg == XS_XFER) && sector_end;
    wire       end_hit     = sector_done && !cnt_ovf && last_sect && last_surf;
    wire       ending      = sector_done && (cnt_ovf || end_hit || stop_reg
                             || late_hit);
    // Done waits until the words already taken have reached memory, unless the late deadline is hit
    wire       drained     = !f_valid && !chan_req;
    wire       finish      = (xs_reg == XS_NEXT) && (drained || late_hit);
    wire       any_err = seek_err_reg | end_err_reg | addr_err_reg | chk_err_reg | late_reg;

    // ----------------------------------------
    // Address/count register
    // ----------------------------------------
    always_ff @(posedge clk or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            da_reg  <= DA_RESET;
            fmt_reg <= 4'h0;
        end else if (load_disc_address_instr) begin
            da_reg  <= accumulator;
            fmt_reg <= accumulator[DA_FORMAT] ? (4'b0001 << accumulator[DA_DRIVE_HI -: 2])
                       : 4'h0;
        end else if (sector_done) begin
            da_reg[DA_CNT_HI:0] <= cnt_next;
            if (last_sect) begin
                da_reg[DA_SECT_HI:DA_SECT_LO] <= 4'h0;
                if (!last_surf) begin
                    da_reg[DA_SURF_HI:DA_SURF_LO] <=
                        5'(da_reg[DA_SURF_HI:DA_SURF_LO] + 5'h1);
                end
            end else begin
                da_reg[DA_SECT_HI:DA_SECT_LO] <=
                    4'(da_reg[DA_SECT_HI:DA_SECT_LO] + 4'h1);
            end
        end
    end

    // Command/cylinder register and word pointer
    always_ff @(posedge clk or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            cmdcyl_reg <= 16'h0000;
            ptr_reg    <= PTR_RESET;
        end else begin
            if (load_cmd_instr) cmdcyl_reg <= accumulator;
            if (load_ptr_instr) ptr_reg <= accumulator[14:0];
            else if (word_moved) ptr_reg <= 15'(ptr_reg + 15'h1);
        end
    end

    // ----------------------------------------
    // Transfer sequencer: one transfer at a time
    // ----------------------------------------
    always_ff @(posedge clk or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            xs_reg       <= XS_IDLE;
            late_cnt_reg <= 16'h0000;
            stop_reg     <= 1'b0;
        end else if (clear_fn) begin
            xs_reg       <= XS_IDLE;
            stop_reg     <= 1'b0;
            late_cnt_reg <= 16'h0000;
        end else begin
            case (xs_reg)
                XS_IDLE: begin
                    stop_reg <= 1'b0;
                    if (launch_rw) xs_reg <= XS_XFER;
                end
                XS_XFER: begin
                    if (late_hit) stop_reg <= 1'b1;
                    if (addr_mismatch) stop_reg <= 1'b1;
                    if (ending) xs_reg <= XS_NEXT;
                end
                XS_NEXT: begin
                    if (finish) xs_reg <= XS_IDLE;
                end
                default: xs_reg <= XS_IDLE;
            endcase
            late_cnt_reg <= (!chan_req || chan_ack) ? 16'h0000
                            : 16'(late_cnt_reg + 16'h1);
        end
    end

    // ----------------------------------------
    // Flags
    // ----------------------------------------
    always_ff @(posedge clk or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            busy_reg     <= 1'b0;
            done_reg     <= 1'b0;
            seek_err_reg <= 1'b0;
            end_err_reg  <= 1'b0;
            addr_err_reg <= 1'b0;
            chk_err_reg  <= 1'b0;
            late_reg     <= 1'b0;
        end else if (clear_fn) begin
            busy_reg     <= 1'b0;
            done_reg     <= 1'b0;
            seek_err_reg <= 1'b0;
            end_err_reg  <= 1'b0;
            addr_err_reg <= 1'b0;
            chk_err_reg  <= 1'b0;
            late_reg     <= 1'b0;
        end else begin
            // Start clears errors; a same-cycle set still wins below
            if (start_fn) begin
                busy_reg     <= 1'b1;
                done_reg     <= 1'b0;
                seek_err_reg <= 1'b0;
                end_err_reg  <= 1'b0;
                addr_err_reg <= 1'b0;
                chk_err_reg  <= 1'b0;
                late_reg     <= 1'b0;
            end else if (finish) begin
                busy_reg <= 1'b0;
                done_reg <= 1'b1;
            end else if (busy_reg && !cmd_rw && |(drive_seek_done & sel_hot)) begin
                busy_reg <= 1'b0;
            end
            if (|(drive_seek_fail & sel_hot)) seek_err_reg <= 1'b1;
            if (end_hit) end_err_reg <= 1'b1;
            if (addr_mismatch || drive_unsafe[sel]) addr_err_reg <= 1'b1;
            if (sector_done && check_mismatch) chk_err_reg <= 1'b1;
            if (late_hit) late_reg <= 1'b1;
        end
    end

    // Per-drive seek tracking; completion set wins over the command-load clear, clear_fn wins over both
    always_ff @(posedge clk or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            seeking_reg <= 4'h0;
            sdone_reg   <= 4'h0;
        end else if (clear_fn) begin
            seeking_reg <= 4'h0;
            sdone_reg   <= 4'h0;
        end else begin
            seeking_reg <= (seeking_reg & ~drive_seek_done)
                           | (launch_seek ? sel_hot : 4'h0);
            sdone_reg   <= (sdone_reg & ~(load_cmd_instr ?
                           {accumulator[11], accumulator[12], accumulator[13],
                            accumulator[14]} : 4'h0))
                           | (drive_seek_done & seeking_reg);
        end
    end

    // ----------------------------------------
    // Data path through the FIFO
    // ----------------------------------------
    word_fifo #(.WIDTH(16), .DEPTH(FIFO_DEPTH)) u_fifo (
        .clk       (clk),
        .rst_n     (rst_sync_n),
        .flush     (clear_fn || xs_reg == XS_IDLE),
        .in_valid  (took_word),
        .in_ready  (f_ready),
        .in_data   (disc_word),
        .out_valid (f_valid),
        .out_ready (!chan_req || chan_ack),
        .out_data  (f_data)
    );

    // Channel request holds until acknowledged, or until clear or the sequencer returning to idle drops it
    always_ff @(posedge clk or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            chan_req  <= 1'b0;
            chan_data <= 16'h0000;
        end else if (clear_fn || xs_reg == XS_IDLE) begin
            chan_req  <= 1'b0;
        end else if (!chan_req || chan_ack) begin
            chan_req  <= f_valid;
            chan_data <= f_data;
        end
    end

    // ----------------------------------------
    // Registered outputs
    // ----------------------------------------
    wire [15:0] flags_next = {done_reg,
                              sdone_reg[0], sdone_reg[1], sdone_reg[2], sdone_reg[3],
                              seeking_reg[0], seeking_reg[1], seeking_reg[2],
                              seeking_reg[3],
                              drive_ready[sel] && !seeking_reg[sel],
                              seek_err_reg, end_err_reg, addr_err_reg, chk_err_reg,
                              late_reg, any_err};
    always_ff @(posedge clk or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            controller_flags        <= 16'h0000;
            disc_position_and_count <= DA_RESET;
            word_ptr                <= PTR_RESET;
            busy                    <= 1'b0;
            intr_req                <= 1'b0;
            format_mode             <= 4'h0;
            seek_strobe             <= 4'h0;
            seek_kind               <= 2'b00;
            seek_cyl                <= 8'h00;
            disc_word_ready         <= 1'b0;
            chan_addr               <= PTR_RESET;
        end else begin
            controller_flags        <= flags_next;
            disc_position_and_count <= da_reg;
            word_ptr                <= ptr_reg;
            busy                    <= busy_reg;
            intr_req                <= done_reg || (|sdone_reg);
            format_mode             <= fmt_reg;
            seek_strobe             <= launch_seek ? sel_hot : 4'h0;
            seek_kind               <= cmd;
            seek_cyl                <= cmdcyl_reg[7:0];
            disc_word_ready         <= f_ready && (xs_reg == XS_XFER) && !took_word;
            chan_addr               <= ptr_next;
        end
    end

    // ----------------------------------------
    // Checks
    // ----------------------------------------
    property p_intr;
        @(posedge clk) disable iff (!rst_sync_n)
        (done_reg || |sdone_reg) |=> intr_req;
    endproperty
    a_intr: assert property (p_intr) else $error("intr missing");
    property p_clear;
        @(posedge clk) disable iff (!rst_sync_n)
        clear_fn |=> !busy_reg && !done_reg && !any_err && xs_reg == XS_IDLE;
    endproperty
    a_clear: assert property (p_clear) else $error("clear failed");
    property p_start;
        @(posedge clk) disable iff (!rst_sync_n)
        (start_fn && !clear_fn) |=> busy_reg && !done_reg;
    endproperty
    a_start: assert property (p_start) else $error("start failed");
    property p_pulse;
        @(posedge clk) disable iff (!rst_sync_n)
        (pulse_fn && !start_fn && !clear_fn && !finish) |=> busy_reg == $past(busy_reg);
    endproperty
    a_pulse: assert property (p_pulse) else $error("pulse moved busy");
    property p_ptr;
        @(posedge clk) disable iff (!rst_sync_n)
        (word_moved && !load_ptr_instr) |=> ptr_reg == 15'($past(ptr_reg) + 15'h1);
    endproperty
    a_ptr: assert property (p_ptr) else $error("pointer stuck");
    property p_cnt;
        @(posedge clk) disable iff (!rst_sync_n)
        (sector_done && !load_disc_address_instr) |=> da_reg[3:0] == $past(cnt_next);
    endproperty
    a_cnt: assert property (p_cnt) else $error("count stuck");
    property p_sum;
        @(posedge clk) disable iff (!rst_sync_n)
        controller_flags[ST_ERROR] == |controller_flags[ST_SEEK_ERR:ST_LATE];
    endproperty
    a_sum: assert property (p_sum) else $error("summary wrong");
    property p_fin;
        @(posedge clk) disable iff (!rst_sync_n)
        (finish && !clear_fn && !start_fn) |=> done_reg && !busy_reg ##1 intr_req;
    endproperty
    a_fin: assert property (p_fin) else $error("finish wrong");
    c_rw:   cover property (@(posedge clk) sector_done ##[1:100] finish);
    c_seek: cover property (@(posedge clk) launch_seek ##[1:1000] |sdone_reg);
    c_late: cover property (@(posedge clk) late_hit);
endmodule

// ==== include/disc_ctl_pkg.sv ====
package disc_ctl_pkg;
    // ----------------------------------------
    // Field layout (bit 0 is the MSB in the documented numbering)
    // ----------------------------------------
    localparam int DRIVES          = 4;
    localparam int DA_DRIVE_HI     = 15;
    localparam int DA_FORMAT       = 13;
    localparam int DA_SURF_HI      = 12;
    localparam int DA_SURF_LO      = 8;
    localparam int DA_SECT_HI      = 7;
    localparam int DA_SECT_LO      = 4;
    localparam int DA_CNT_HI       = 3;
    localparam logic [4:0] LAST_SURFACE = 5'h13;
    localparam logic [3:0] LAST_SECTOR  = 4'hb;
    localparam int ST_RW_DONE      = 15;
    localparam int ST_SEEK_DONE_HI = 14;
    localparam int ST_SEEKING_HI   = 10;
    localparam int ST_READY        = 6;
    localparam int ST_SEEK_ERR     = 5;
    localparam int ST_END_ERR      = 4;
    localparam int ST_ADDR_ERR     = 3;
    localparam int ST_CHECK_ERR    = 2;
    localparam int ST_LATE         = 1;
    localparam int ST_ERROR        = 0;
    localparam logic [15:0] DA_RESET = 16'h0000;
    localparam logic [14:0] PTR_RESET = 15'h0000;
    // ----------------------------------------
    // Commands and timing
    // ----------------------------------------
    typedef enum logic [1:0] {
        CMD_READ  = 2'b00,
        CMD_WRITE = 2'b01,
        CMD_SEEK  = 2'b10,
        CMD_RECAL = 2'b11
    } cmd_t;
    typedef enum logic [1:0] {
        XS_IDLE = 2'b00,
        XS_XFER = 2'b01,
        XS_NEXT = 2'b10
    } xfer_state_t;
    localparam real CLK_MHZ        = 100.0;
    localparam real LATE_US        = 25.6;
    localparam int  LATE_CYCLES    = int'($floor(LATE_US * CLK_MHZ));
    localparam logic [8:0] WORDS_PER_SECTOR = 9'h100;
    localparam int FIFO_DEPTH = 4;
endpackage

// ==== verification/disc_far_end.sv ====
`timescale 1ns/1ps
// ----------------------------------------
// Drive read stream, seek answers and data channel
// ----------------------------------------
module disc_far_end (
    input  wire logic        clk,
    input  wire logic        go,
    input  wire logic        late_first,
    input  wire logic        check_bad,
    input  wire logic [3:0]  seek_strobe,
    input  wire logic        disc_word_ready,
    input  wire logic        chan_req,
    input  wire logic [15:0] chan_data,
    output logic [3:0]       drive_seek_done,
    output logic             disc_word_valid,
    output logic [15:0]      disc_word,
    output logic             sector_end,
    output logic             check_mismatch,
    output logic             chan_ack,
    output logic [15:0]      n_words,
    output logic [15:0]      last_data
);
    logic       first;
    logic [3:0] pending;
    // One sector of 256 words; released data line shows the inverse
    initial begin
        disc_word_valid = 1'b0;
        disc_word = 16'h0000;
        sector_end = 1'b0;
        check_mismatch = 1'b0;
        forever begin
            @(posedge clk);
            if (go) begin
                for (int i = 0; i < 256; i++) begin
                    disc_word_valid <= 1'b1;
                    disc_word <= 16'h5a00 + 16'(i);
                    do @(posedge clk); while (disc_word_ready !== 1'b1);
                end
                disc_word_valid <= 1'b0;
                disc_word <= ~disc_word;
                sector_end <= 1'b1;
                check_mismatch <= check_bad;
                @(posedge clk);
                sector_end <= 1'b0;
                check_mismatch <= 1'b0;
            end
        end
    end
    // Channel answers in 2 cycles, or misses the first deadline on purpose
    initial begin
        chan_ack = 1'b0;
        n_words = 16'h0000;
        last_data = 16'h0000;
        first = 1'b0;
        forever begin
            @(posedge clk);
            if (go) begin
                n_words <= 16'h0000;
                first <= late_first;
            end else if (chan_req === 1'b1) begin
                repeat (first ? 2700 : 2) @(posedge clk);
                chan_ack <= 1'b1;
                n_words <= n_words + 16'h0001;
                last_data <= chan_data;
                first <= 1'b0;
                @(posedge clk);
                chan_ack <= 1'b0;
                @(posedge clk);
            end
        end
    end
    // Heads settle 20 cycles after the strobe
    initial begin
        drive_seek_done = 4'h0;
        forever begin
            @(posedge clk);
            pending = seek_strobe;
            if (|pending) begin
                repeat (20) @(posedge clk);
                drive_seek_done <= pending;
                @(posedge clk);
                drive_seek_done <= 4'h0;
            end
        end
    end
endmodule

// ==== verification/moving_head_disc_controller_tb.sv ====
`timescale 1ns/1ps
module moving_head_disc_controller_tb;
    import disc_ctl_pkg::*;
    typedef struct packed {logic [15:0] acc; logic [3:0] rdy; logic fmt; logic ready;} row_t;
    localparam logic [5:0] F_START = 6'h20, F_CLEAR = 6'h10, F_PULSE = 6'h08;
    localparam logic [5:0] L_DA = 6'h04, L_CMD = 6'h02, L_PTR = 6'h01;
    row_t rows [4] = '{'{16'h2000, 4'b0001, 1'b1, 1'b1}, '{16'h4000, 4'b0001, 1'b0, 1'b0},
                       '{16'ha15f, 4'b0100, 1'b1, 1'b1}, '{16'hd3bf, 4'b0111, 1'b0, 1'b0}};
    logic clk, rst_n, start_fn, clear_fn, pulse_fn, ld_da, ld_cmd, ld_ptr, busy, intr_req;
    logic go, late_first, check_bad, dwv, dwr, sector_end, chk_mis, chan_req, chan_ack;
    logic [15:0] accumulator, flags, dpc, disc_word, chan_data, n_words, last_data;
    logic [14:0] word_ptr, chan_addr;
    logic [3:0]  format_mode, seek_strobe, drive_ready, seek_done, seek_fail, unsafe;
    logic [1:0]  seek_kind;
    logic [7:0]  seek_cyl;
    int          n_fail, total_checks, cycles;

    // ----------------------------------------
    // Design and far side
    // ----------------------------------------
    disc_ctl DUT (.clk(clk), .rst_n(rst_n), .start_fn(start_fn), .clear_fn(clear_fn),
        .pulse_fn(pulse_fn), .load_disc_address_instr(ld_da), .load_cmd_instr(ld_cmd),
        .load_ptr_instr(ld_ptr), .accumulator(accumulator), .controller_flags(flags),
        .disc_position_and_count(dpc), .word_ptr(word_ptr), .busy(busy), .intr_req(intr_req),
        .format_mode(format_mode), .seek_strobe(seek_strobe), .seek_kind(seek_kind),
        .seek_cyl(seek_cyl), .drive_seek_done(seek_done), .drive_seek_fail(seek_fail),
        .drive_ready(drive_ready), .drive_unsafe(unsafe), .disc_word_valid(dwv),
        .disc_word_ready(dwr), .disc_word(disc_word), .sector_end(sector_end),
        .check_mismatch(chk_mis), .addr_mismatch(1'b0), .chan_req(chan_req),
        .chan_data(chan_data), .chan_addr(chan_addr), .chan_ack(chan_ack));
    disc_far_end FAR (.clk(clk), .go(go), .late_first(late_first), .check_bad(check_bad),
        .seek_strobe(seek_strobe), .disc_word_ready(dwr), .chan_req(chan_req),
        .chan_data(chan_data), .drive_seek_done(seek_done), .disc_word_valid(dwv),
        .disc_word(disc_word), .sector_end(sector_end), .check_mismatch(chk_mis),
        .chan_ack(chan_ack), .n_words(n_words), .last_data(last_data));

    // ----------------------------------------
    // Tasks
    // ----------------------------------------
    task automatic chk(input string name, input logic [15:0] exp, input logic [15:0] got);
        total_checks++;
        if (got !== exp) begin
            n_fail++;
            $display("wrong value %s expected %h seen %h", name, exp, got);
        end
    endtask
    // One-cycle strobe, then let the 2-cycle answer settle
    task automatic op(input logic [5:0] f, input logic [15:0] v);
        {start_fn, clear_fn, pulse_fn, ld_da, ld_cmd, ld_ptr} <= f;
        accumulator <= v;
        @(posedge clk);
        {start_fn, clear_fn, pulse_fn, ld_da, ld_cmd, ld_ptr} <= 6'h00;
        repeat (3) @(posedge clk);
    endtask
    // Read from drive 0 into word address 0100
    task automatic run_read(input logic bad, input logic [15:0] da);
        late_first <= bad;
        check_bad <= bad;
        op(L_PTR, 16'h0100);
        op(L_DA, da);
        op(L_CMD, 16'h0000);
        op(F_START, 16'h0000);
        chk("busy", 16'h0001, {15'h0, busy});
        go <= 1'b1;
        @(posedge clk);
        go <= 1'b0;
        for (int i = 0; i < 8000 && busy !== 1'b0; i++) @(posedge clk);
        repeat (3) @(posedge clk);
    endtask
    task automatic end_of_test;
        $display("checks %0d mismatches %0d", total_checks, n_fail);
        if (n_fail == 0 && total_checks > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask

    // Hang guard, well above the roughly 7000 cycles the run needs
    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            n_fail++;
            end_of_test;
        end
    end
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    // ----------------------------------------
    // Main sequence
    // ----------------------------------------
    initial begin
        {rst_n, start_fn, clear_fn, pulse_fn, ld_da, ld_cmd, ld_ptr} = 7'h00;
        {go, late_first, check_bad, accumulator, drive_ready, seek_fail, unsafe} = '0;
        n_fail = 0;
        total_checks = 0;
        cycles = 0;
        repeat (2) @(posedge clk);
        chk("flags", 16'h0000, flags);
        chk("busy intr", 16'h0000, {14'h0, busy, intr_req});
        rst_n <= 1'b1;
        repeat (3) @(posedge clk);
        foreach (rows[i]) begin
            drive_ready <= rows[i].rdy;
            op(L_DA, rows[i].acc);
            chk("position", rows[i].acc, dpc);
            chk("format", {15'h0, rows[i].fmt}, {15'h0, format_mode[rows[i].acc[15:14]]});
            chk("ready", {15'h0, rows[i].ready}, {15'h0, flags[ST_READY]});
        end
        drive_ready <= 4'hf;
        // Seek on drive 1, recalibrate on drive 2, both by pulse
        for (int k = 0; k < 2; k++) begin
            op(L_DA, 16'(k + 1) << 14);
            op(L_CMD, {6'h00, 2'b10 | 2'(k), 8'h05});
            op(F_PULSE, 16'h0000);
            chk("busy", 16'h0000, {15'h0, busy});
            chk("seeking", 16'h0001, {15'h0, flags[ST_SEEKING_HI - k - 1]});
            chk("kind", {14'h0, 2'b10 | 2'(k)}, {14'h0, seek_kind});
            chk("cylinder", 16'h0005, {8'h0, seek_cyl});
            repeat (30) @(posedge clk);
            chk("seek done", 16'h0001, {15'h0, flags[ST_SEEK_DONE_HI - k - 1]});
            chk("intr", 16'h0001, {15'h0, intr_req});
            op(L_CMD, 16'h0001 << (ST_SEEK_DONE_HI - k - 1));
            chk("intr", 16'h0000, {15'h0, intr_req});
        end
        run_read(1'b0, 16'h000f);
        chk("pointer", 16'h0200, {1'b0, word_ptr});
        chk("position", 16'h0010, dpc);
        chk("words", 16'h0100, n_words);
        chk("data", 16'h5aff, last_data);
        chk("done", 16'h0001, {15'h0, flags[ST_RW_DONE]});
        chk("busy intr", 16'h0001, {14'h0, busy, intr_req});
        op(F_CLEAR, 16'h0000);
        chk("done intr", 16'h0000, {14'h0, flags[ST_RW_DONE], intr_req});
        // Late channel plus bad checkword, then a restart and an abort
        run_read(1'b1, 16'h000f);
        chk("errors", 16'h0007, {10'h0, flags[5:0]});
        op(F_START, 16'h0000);
        chk("restart", 16'h0000, {flags[ST_RW_DONE], 9'h0, flags[5:0]});
        op(F_CLEAR, 16'h0000);
        chk("busy", 16'h0000, {15'h0, busy});
        // Drive 0 reports a failed seek and a fault
        {seek_fail, unsafe} <= 8'h11;
        @(posedge clk);
        {seek_fail, unsafe} <= 8'h00;
        repeat (3) @(posedge clk);
        chk("errors", 16'h0029, {10'h0, flags[5:0]});
        // Two sectors asked from the last sector of the last surface
        run_read(1'b0, 16'h13be);
        chk("errors", 16'h0011, {10'h0, flags[5:0]});
        chk("position", 16'h130f, dpc);
        chk("chan addr", 16'h0200, {1'b0, chan_addr});
        end_of_test;
    end
endmodule
